// *** include/cibx_pkg.sv ***
// Shared constants and types for the core integer and branch execute block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package cibx_pkg;
	localparam int unsigned CIBX_DW        = 32;
	localparam int unsigned CIBX_AW        = 8;
	// Register byte offsets
	localparam logic [7:0] CIBX_OFF_CMD    = 8'h00;
	localparam logic [7:0] CIBX_OFF_SRC1   = 8'h04;
	localparam logic [7:0] CIBX_OFF_SRC2   = 8'h08;
	localparam logic [7:0] CIBX_OFF_PC     = 8'h0C;
	localparam logic [7:0] CIBX_OFF_FREG   = 8'h10;
	localparam logic [7:0] CIBX_OFF_MERGE  = 8'h14;
	localparam logic [7:0] CIBX_OFF_FLAGS  = 8'h18;
	localparam logic [7:0] CIBX_OFF_RESULT = 8'h1C;
	localparam logic [7:0] CIBX_OFF_LINK   = 8'h20;
	localparam logic [7:0] CIBX_OFF_NPC    = 8'h24;
	localparam logic [7:0] CIBX_OFF_SEQ    = 8'h28;
	// Command word fields
	localparam int unsigned CIBX_CMD_OP_LSB  = 0;
	localparam int unsigned CIBX_CMD_OP_W    = 5;
	localparam int unsigned CIBX_CMD_IMM_BIT = 5;
	localparam int unsigned CIBX_CMD_K_LSB   = 6;
	localparam int unsigned CIBX_LONG_W      = 26;
	localparam int unsigned CIBX_SHORT_W     = 16;
	localparam int unsigned CIBX_IMM_W       = 16;
	localparam int unsigned CIBX_SCMP_W      = 5;
	localparam int unsigned CIBX_ZFIELD_W    = 32;
	// Flag register fields
	localparam int unsigned CIBX_FLG_COND  = 0;
	localparam int unsigned CIBX_FLG_OVF   = 1;
	localparam int unsigned CIBX_FLG_LOOP  = 2;
	localparam int unsigned CIBX_FLG_DSW   = 3;
	localparam int unsigned CIBX_FLG_DUAL  = 4;
	localparam int unsigned CIBX_FLG_TRAP  = 5;
	localparam int unsigned CIBX_FLG_MODE  = 6;
	localparam int unsigned CIBX_FLG_W     = 7;
	// Sequencing status fields
	localparam int unsigned CIBX_SEQ_REDIR = 0;
	localparam int unsigned CIBX_SEQ_SLOT  = 1;
	localparam int unsigned CIBX_SEQ_ANNUL = 2;
	localparam int unsigned CIBX_SEQ_ILL   = 3;
	localparam int unsigned CIBX_SEQ_W     = 4;
	// Reset values and address steps
	localparam logic [31:0] CIBX_RST_WORD  = 32'h00000000;
	localparam logic [31:0] CIBX_INSN_STEP = 32'h00000004;
	localparam logic [1:0]  CIBX_SW_COUNT  = 2'h2;
	typedef enum logic [4:0] {
		OP_NOP, OP_SIGNED_ADD, OP_AND, OP_AND_HIGH, OP_AND_COMPLEMENT, OP_AND_COMPLEMENT_HIGH,
		OP_BRANCH_ON_SET, OP_BRANCH_ON_SET_TAKEN, OP_BRANCH_ON_CLEAR, OP_BRANCH_ON_CLEAR_TAKEN,
		OP_LOOP_ADD, OP_DIRECT_JUMP, OP_INDIRECT_JUMP, OP_SUBROUTINE_JUMP, OP_INDIRECT_SUBROUTINE_JUMP,
		OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_UNEQUAL, OP_FLOAT_LOAD_INC, OP_FLOAT_STORE_INC,
		OP_MERGE_OR, OP_ZCHECK_WIDE, OP_FLOAT_TO_INT, OP_FLOAT_NOP
	} cibx_op_t;
endpackage : cibx_pkg

// *** include/cibx_alu_if.sv ***
// Operand and result bundle between the execute core and its datapath.
// Assumes the core drives operands combinationally in the issuing cycle.
`timescale 1ns/1ps
interface cibx_alu_if;
	import cibx_pkg::*;
	cibx_op_t               op;
	logic                   imm_sel;
	logic [CIBX_LONG_W-1:0] kfield;
	logic [31:0]            src1;
	logic [31:0]            src2;
	logic [31:0]            merge;
	logic [31:0]            freg;
	logic [31:0]            result;
	logic [31:0]            sum;
	logic                   cond_new;
	logic                   cond_wr;
	logic                   ovf_new;
	logic                   loop_tmp;
	logic                   equal;
	modport alu  (input op, imm_sel, kfield, src1, src2, merge, freg,
		output result, sum, cond_new, cond_wr, ovf_new, loop_tmp, equal);
	modport core (output op, imm_sel, kfield, src1, src2, merge, freg,
		input result, sum, cond_new, cond_wr, ovf_new, loop_tmp, equal);
endinterface : cibx_alu_if

// *** hw/cibx_target.sv ***
// Relative branch target adder for one offset width.
// Assumes the instruction address is word aligned.
`timescale 1ns/1ps
module cibx_target
	import cibx_pkg::*;
#(
	parameter int unsigned OFF_W = CIBX_LONG_W
) (
	input  wire logic [31:0]      insn_addr,
	input  wire logic [OFF_W-1:0] offset,
	output logic      [31:0]      target
);
	logic [31:0] disp;

	// Word offset scaled by four and sign-extended
	assign disp   = {{(30 - OFF_W){offset[OFF_W-1]}}, offset, 2'b00};
	assign target = insn_addr + CIBX_INSN_STEP + disp;
endmodule : cibx_target

// *** hw/cibx_alu.sv ***
// Combinational datapath: operand shaping, add, logic, merge and minimum.
// Assumes the core samples every output in the same cycle it drives the operands.
`timescale 1ns/1ps
module cibx_alu
	import cibx_pkg::*;
(
	cibx_alu_if.alu bus
);
	logic [31:0] opa;
	logic [31:0] hi_k;
	logic [31:0] neg_a;
	logic [32:0] sum33;
	logic [31:0] low31;
	logic [31:0] zmin;
	logic        lt_neg;

	// Immediate shaping depends on the operation family
	always_comb begin
		opa = bus.src1;
		if (bus.imm_sel) begin
			case (bus.op)
				OP_SIGNED_ADD:                        opa = {{16{bus.kfield[15]}}, bus.kfield[15:0]};
				OP_AND, OP_AND_COMPLEMENT:            opa = {16'h0000, bus.kfield[15:0]};
				OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_UNEQUAL: opa = {27'h0000000, bus.kfield[CIBX_SCMP_W-1:0]};
				default:                              opa = bus.src1;
			endcase
		end
	end

	// Carries out of bits 30 and 31 and the signed compare against the negation
	assign hi_k   = {bus.kfield[CIBX_IMM_W-1:0], 16'h0000};
	assign sum33  = {1'b0, opa} + {1'b0, bus.src2};
	assign low31  = {1'b0, opa[30:0]} + {1'b0, bus.src2[30:0]};
	assign neg_a  = ~opa + 32'h00000001;
	assign lt_neg = $signed(bus.src2) < $signed(neg_a);
	assign bus.sum      = sum33[31:0];
	assign bus.ovf_new  = sum33[32] ^ low31[31];
	assign bus.loop_tmp = ~lt_neg;
	assign bus.equal    = (opa == bus.src2);

	// Per-field unsigned minimum; fields narrower than a word repeat here
	genvar f;
	generate
		for (f = 0; f < 32 / CIBX_ZFIELD_W; f++) begin : g_zf
			assign zmin[f*CIBX_ZFIELD_W +: CIBX_ZFIELD_W] =
				(bus.src2[f*CIBX_ZFIELD_W +: CIBX_ZFIELD_W] <= opa[f*CIBX_ZFIELD_W +: CIBX_ZFIELD_W]) ?
				bus.src2[f*CIBX_ZFIELD_W +: CIBX_ZFIELD_W] : opa[f*CIBX_ZFIELD_W +: CIBX_ZFIELD_W];
		end
	endgenerate

	// Result selection and condition flag update
	always_comb begin
		bus.result   = 32'h00000000;
		bus.cond_wr  = 1'b0;
		bus.cond_new = 1'b0;
		case (bus.op)
			OP_SIGNED_ADD: begin
				bus.result   = sum33[31:0];
				bus.cond_wr  = 1'b1;
				bus.cond_new = lt_neg;
			end
			OP_AND, OP_AND_HIGH, OP_AND_COMPLEMENT, OP_AND_COMPLEMENT_HIGH: begin
				case (bus.op)
					OP_AND:            bus.result = opa & bus.src2;
					OP_AND_HIGH:       bus.result = hi_k & bus.src2;
					OP_AND_COMPLEMENT: bus.result = ~opa & bus.src2;
					default:           bus.result = ~hi_k & bus.src2;
				endcase
				bus.cond_wr  = 1'b1;
				bus.cond_new = (bus.result == 32'h00000000);
			end
			OP_FLOAT_LOAD_INC, OP_FLOAT_STORE_INC: bus.result = sum33[31:0];
			OP_MERGE_OR:     bus.result = bus.src1 | bus.merge;
			OP_ZCHECK_WIDE:  bus.result = zmin;
			OP_FLOAT_TO_INT: bus.result = bus.freg;
			default:         bus.result = 32'h00000000;
		endcase
	end
endmodule : cibx_alu

// *** hw/cibx_core.sv ***
// Core integer and branch execute block with an APB register front end.
// Assumes the issue side writes operands first and then the command word,
// which executes the operation at the edge that completes that write.
//
// Overview of operation
// - Signed add writes the sum; overflow is carry31 differing from carry30.
// - Signed add sets condition when src2 is below the negated src1.
// - Every logical operation sets condition exactly when its result is zero.
// - High variants shift constant left sixteen; complement variants invert it after the shift.
// - Plain conditional branches jump on set or clear, else fall through.
// - Taken branch on set runs one slot then jumps, else annuls next.
// - Taken branch on clear mirrors that, testing the flag for zero.
// - Loop add forms temporary flag from signed compare and writes sum to src2.
// - Trap return indirect jump steps instruction mode per switch and dual flags.
// - Autoincrement float load and store write effective address back to src2.
// - Merge OR writes src1 OR accumulator, then clears the accumulator.
// - Wide Z check writes unsigned per-field minimum, then clears the accumulator.
// - Float to integer transfer copies the float source unchanged.
// - Float no-operation leaves result, operands and all flags but mode untouched; only next address, sequencing status and a pending mode countdown update.
// - Target is offset times four, sign-extended, plus instruction address plus four.
// - Long offset is signed 26 bits, short offset signed 16 bits.
// - Sixteen-bit immediate is sign-extended for add, zero-extended for logic.
// - Compare branches take a register or a zero-extended five-bit immediate.
`timescale 1ns/1ps
module cibx_core
	import cibx_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cibx_pkg::CIBX_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr
);
	import cibx_pkg::*;

	cibx_alu_if alu_bus ();

	logic                  pready_q;
	logic [31:0]           prdata_q;
	logic                  pslverr_q;
	logic [31:0]           cmd_q;
	logic [31:0]           src1_q;
	logic [31:0]           src2_q;
	logic [31:0]           pc_q;
	logic [31:0]           freg_q;
	logic [31:0]           merge_q;
	logic [31:0]           result_q;
	logic [31:0]           link_q;
	logic [31:0]           npc_q;
	logic [CIBX_SEQ_W-1:0] seq_q;
	logic                  cond_q;
	logic                  ovf_q;
	logic                  loop_q;
	logic                  dsw_q;
	logic                  dual_q;
	logic                  trap_q;
	logic                  mode_q;
	logic                  pend_mode_q;
	logic [1:0]            pend_cnt_q;
	logic                  acc;
	logic                  wr_acc;
	logic                  exec;
	cibx_op_t              op_w;
	logic [31:0]           long_tgt;
	logic [31:0]           short_tgt;
	logic [31:0]           npc_d;
	logic [CIBX_SEQ_W-1:0] seq_d;
	logic [31:0]           rd_d;

	// Address decode shared by the read mux and the write strobes
	function automatic logic mapped(input logic [CIBX_AW-1:0] a);
		mapped = (a <= CIBX_OFF_SEQ) && (a[1:0] == 2'b00);
	endfunction : mapped

	assign acc    = psel & penable & pready_q;
	assign wr_acc = acc & pwrite & mapped(paddr);
	assign exec   = wr_acc & (paddr == CIBX_OFF_CMD);
	assign op_w   = cibx_op_t'(pwdata[CIBX_CMD_OP_LSB +: CIBX_CMD_OP_W]);

	// Datapath opcode and constant come straight from the command word being written; operands come from registers
	assign alu_bus.op      = op_w;
	assign alu_bus.imm_sel = pwdata[CIBX_CMD_IMM_BIT];
	assign alu_bus.kfield  = pwdata[CIBX_CMD_K_LSB +: CIBX_LONG_W];
	assign alu_bus.src1    = src1_q;
	assign alu_bus.src2    = src2_q;
	assign alu_bus.merge   = merge_q;
	assign alu_bus.freg    = freg_q;

	cibx_alu u_alu (
		.bus (alu_bus.alu)
	);

	cibx_target #(.OFF_W(CIBX_LONG_W)) u_long (
		.insn_addr (pc_q),
		.offset    (pwdata[CIBX_CMD_K_LSB +: CIBX_LONG_W]),
		.target    (long_tgt)
	);

	cibx_target #(.OFF_W(CIBX_SHORT_W)) u_short (
		.insn_addr (pc_q),
		.offset    (pwdata[CIBX_CMD_K_LSB +: CIBX_SHORT_W]),
		.target    (short_tgt)
	);

	// Sequencing decision: next fetch address, delay slot and annul
	always_comb begin
		npc_d = pc_q + CIBX_INSN_STEP;
		seq_d = '0;
		unique case (op_w)
			OP_BRANCH_ON_SET, OP_BRANCH_ON_CLEAR: begin
				if (cond_q == (op_w == OP_BRANCH_ON_SET)) begin
					npc_d = long_tgt;
					seq_d[CIBX_SEQ_REDIR] = 1'b1;
				end
			end
			OP_BRANCH_ON_SET_TAKEN, OP_BRANCH_ON_CLEAR_TAKEN: begin
				if (cond_q == (op_w == OP_BRANCH_ON_SET_TAKEN)) begin
					npc_d = long_tgt;
					seq_d[CIBX_SEQ_REDIR] = 1'b1;
					seq_d[CIBX_SEQ_SLOT]  = 1'b1;
				end else begin
					seq_d[CIBX_SEQ_ANNUL] = 1'b1;
				end
			end
			OP_LOOP_ADD: begin
				seq_d[CIBX_SEQ_SLOT] = 1'b1;
				if (loop_q) begin
					npc_d = short_tgt;
					seq_d[CIBX_SEQ_REDIR] = 1'b1;
				end
			end
			OP_DIRECT_JUMP, OP_SUBROUTINE_JUMP: begin
				npc_d = long_tgt;
				seq_d[CIBX_SEQ_REDIR] = 1'b1;
				seq_d[CIBX_SEQ_SLOT]  = 1'b1;
			end
			OP_INDIRECT_JUMP, OP_INDIRECT_SUBROUTINE_JUMP: begin
				npc_d = src1_q;
				seq_d[CIBX_SEQ_REDIR] = 1'b1;
				seq_d[CIBX_SEQ_SLOT]  = 1'b1;
			end
			OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_UNEQUAL: begin
				if (alu_bus.equal == (op_w == OP_BRANCH_IF_EQUAL)) begin
					npc_d = short_tgt;
					seq_d[CIBX_SEQ_REDIR] = 1'b1;
				end
			end
			OP_NOP, OP_SIGNED_ADD, OP_AND, OP_AND_HIGH, OP_AND_COMPLEMENT, OP_AND_COMPLEMENT_HIGH,
			OP_FLOAT_LOAD_INC, OP_FLOAT_STORE_INC, OP_MERGE_OR, OP_ZCHECK_WIDE, OP_FLOAT_TO_INT,
			OP_FLOAT_NOP: begin
				npc_d = pc_q + CIBX_INSN_STEP;
			end
			default: seq_d[CIBX_SEQ_ILL] = 1'b1;                             // Unassigned opcode
		endcase
	end

	// APB handshake: one wait state, so every access completes in its second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped(paddr);
		end
	end

	// Read data captured together with pready; unmapped reads return zero
	always_comb begin
		rd_d = 32'h00000000;
		if (mapped(paddr)) begin
			case (paddr)
				CIBX_OFF_CMD:    rd_d = cmd_q;
				CIBX_OFF_SRC1:   rd_d = src1_q;
				CIBX_OFF_SRC2:   rd_d = src2_q;
				CIBX_OFF_PC:     rd_d = pc_q;
				CIBX_OFF_FREG:   rd_d = freg_q;
				CIBX_OFF_MERGE:  rd_d = merge_q;
				CIBX_OFF_FLAGS:  rd_d = {25'h0000000, mode_q, trap_q, dual_q, dsw_q, loop_q, ovf_q, cond_q};
				CIBX_OFF_RESULT: rd_d = result_q;
				CIBX_OFF_LINK:   rd_d = link_q;
				CIBX_OFF_NPC:    rd_d = npc_q;
				CIBX_OFF_SEQ:    rd_d = {28'h0000000, seq_q};
				default:         rd_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= CIBX_RST_WORD;
		end else if (psel & penable & ~pready_q & ~pwrite) begin
			prdata_q <= rd_d;
		end
	end

	// Operand registers: software writes, and autoincrement or loop add write src2 back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q   <= CIBX_RST_WORD;
			src1_q  <= CIBX_RST_WORD;
			src2_q  <= CIBX_RST_WORD;
			pc_q    <= CIBX_RST_WORD;
			freg_q  <= CIBX_RST_WORD;
			merge_q <= CIBX_RST_WORD;
		end else if (wr_acc) begin
			unique case (paddr)
				CIBX_OFF_CMD: begin
					cmd_q <= pwdata;
					if (op_w == OP_LOOP_ADD || op_w == OP_FLOAT_LOAD_INC || op_w == OP_FLOAT_STORE_INC)
						src2_q <= alu_bus.sum;
					if (op_w == OP_MERGE_OR || op_w == OP_ZCHECK_WIDE)
						merge_q <= CIBX_RST_WORD;
				end
				CIBX_OFF_SRC1:  src1_q  <= pwdata;
				CIBX_OFF_SRC2:  src2_q  <= pwdata;
				CIBX_OFF_PC:    pc_q    <= pwdata;
				CIBX_OFF_FREG:  freg_q  <= pwdata;
				CIBX_OFF_MERGE: merge_q <= pwdata;
				default: ;                                                   // Flags written in the flag block; other words read-only
			endcase
		end
	end

	// Execution results; the float no-operation and branches leave result untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= CIBX_RST_WORD;
			link_q   <= CIBX_RST_WORD;
			npc_q    <= CIBX_RST_WORD;
			seq_q    <= '0;
		end else if (exec) begin
			npc_q <= npc_d;
			seq_q <= seq_d;
			case (op_w)
				OP_SIGNED_ADD, OP_AND, OP_AND_HIGH, OP_AND_COMPLEMENT, OP_AND_COMPLEMENT_HIGH,
				OP_FLOAT_LOAD_INC, OP_FLOAT_STORE_INC, OP_MERGE_OR, OP_ZCHECK_WIDE, OP_FLOAT_TO_INT:
					result_q <= alu_bus.result;
				OP_SUBROUTINE_JUMP, OP_INDIRECT_SUBROUTINE_JUMP:
					link_q <= pc_q + CIBX_INSN_STEP + CIBX_INSN_STEP;
				default: ;
			endcase
		end
	end

	// Condition, overflow and loop flags; software may also write them directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 1'b0;
			ovf_q  <= 1'b0;
			loop_q <= 1'b0;
			dsw_q  <= 1'b0;
			dual_q <= 1'b0;
			trap_q <= 1'b0;
		end else if (exec) begin
			if (alu_bus.cond_wr)
				cond_q <= alu_bus.cond_new;
			if (op_w == OP_SIGNED_ADD)
				ovf_q <= alu_bus.ovf_new;
			if (op_w == OP_LOOP_ADD)
				loop_q <= alu_bus.loop_tmp;
			if (op_w == OP_INDIRECT_JUMP)
				trap_q <= 1'b0;                                              // Return clears trap state
		end else if (wr_acc && paddr == CIBX_OFF_FLAGS) begin
			cond_q <= pwdata[CIBX_FLG_COND];
			ovf_q  <= pwdata[CIBX_FLG_OVF];
			loop_q <= pwdata[CIBX_FLG_LOOP];
			dsw_q  <= pwdata[CIBX_FLG_DSW];
			dual_q <= pwdata[CIBX_FLG_DUAL];
			trap_q <= pwdata[CIBX_FLG_TRAP];
		end
	end

	// Instruction mode: a trap return schedules a switch after a count of instructions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q      <= 1'b0;
			pend_mode_q <= 1'b0;
			pend_cnt_q  <= 2'h0;
		end else if (exec) begin
			if (op_w == OP_INDIRECT_JUMP && trap_q) begin
				if (dsw_q) begin
					mode_q      <= dual_q;
					pend_mode_q <= ~dual_q;
					pend_cnt_q  <= 2'h1;
				end else begin
					mode_q      <= dual_q;
					pend_mode_q <= dual_q;
					pend_cnt_q  <= CIBX_SW_COUNT;
				end
			end else if (pend_cnt_q != 2'h0) begin
				pend_cnt_q <= pend_cnt_q - 2'h1;
				if (pend_cnt_q == 2'h1)
					mode_q <= pend_mode_q;
			end
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ADD_SUM_OVF: assert property (exec && op_w == OP_SIGNED_ADD && !pwdata[CIBX_CMD_IMM_BIT] |=>
		result_q == $past(src1_q) + $past(src2_q) && ovf_q == $past(alu_bus.ovf_new))
		else $error("signed add sum or overflow wrong");
	AST_LOGIC_ZERO: assert property (exec && op_w == OP_AND |=> cond_q == (result_q == 32'h00000000))
		else $error("logic condition flag does not follow zero result");
	AST_AND_HIGH_SHIFT: assert property (exec && op_w == OP_AND_HIGH |=> result_q[15:0] == 16'h0000)
		else $error("high and leaked into low half");
	AST_BSET_FALL: assert property (exec && op_w == OP_BRANCH_ON_SET && !cond_q |=>
		npc_q == $past(pc_q) + CIBX_INSN_STEP && seq_q == '0)
		else $error("untaken branch did not fall through");
	AST_BSET_ANNUL: assert property (exec && op_w == OP_BRANCH_ON_SET_TAKEN && !cond_q |=>
		seq_q[CIBX_SEQ_ANNUL] && !seq_q[CIBX_SEQ_REDIR])
		else $error("untaken taken-form branch did not annul");
	AST_LOOP_SLOT: assert property (exec && op_w == OP_LOOP_ADD |=> seq_q[CIBX_SEQ_SLOT] &&
		seq_q[CIBX_SEQ_REDIR] == $past(loop_q) && src2_q == $past(src1_q) + $past(src2_q))
		else $error("loop add slot, branch or writeback wrong");
	AST_CALL_LINK: assert property (exec && op_w == OP_SUBROUTINE_JUMP |=>
		link_q == $past(pc_q) + 32'h00000008 && npc_q == $past(long_tgt))
		else $error("call link or target wrong");
	AST_INC_WB: assert property (exec && op_w == OP_FLOAT_LOAD_INC |=>
		src2_q == $past(src1_q) + $past(src2_q) && result_q == src2_q)
		else $error("autoincrement writeback wrong");
	AST_MERGE_CLR: assert property (exec && (op_w == OP_MERGE_OR || op_w == OP_ZCHECK_WIDE) |=>
		merge_q == 32'h00000000)
		else $error("merge accumulator not cleared");
	AST_EQ_NOSLOT: assert property (exec && op_w == OP_BRANCH_IF_EQUAL && alu_bus.equal |=>
		seq_q[CIBX_SEQ_REDIR] && !seq_q[CIBX_SEQ_SLOT])
		else $error("equal branch redirect or slot wrong");
	AST_MODE_STEP: assert property (exec && op_w == OP_INDIRECT_JUMP && trap_q && dsw_q && dual_q |=>
		mode_q && pend_cnt_q == 2'h1 && !pend_mode_q)
		else $error("trap return mode switch wrong");

	COV_TAKEN_SLOT: cover property (exec && op_w == OP_BRANCH_ON_CLEAR_TAKEN && !cond_q);
	COV_LOOP_BACK: cover property (exec && op_w == OP_LOOP_ADD && loop_q);
	COV_MODE_SWITCH: cover property (pend_cnt_q == 2'h1 ##[1:20] pend_cnt_q == 2'h0);
endmodule : cibx_core

// *** testbench/cibx_issue_model.sv ***
// Issue-side model: an APB master that feeds operands and commands.
// Assumes the slave answers with pready; the bench bounds every wait.
`timescale 1ns/1ps
module cibx_issue_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	// Idle bus at time zero
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h00000000;
	end
	// One transfer, held until pready; released lines show stale-inverted values
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : cibx_issue_model

// *** testbench/cibx_core_tb.sv ***
// Self-checking bench for the integer and branch execute block.
// Assumes the issue model drives APB; expectations come from local functions.
`timescale 1ns/1ps
module cibx_core_tb;
	import cibx_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e, c, t;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, s1, s2, pc, r, opnd, cmpv;
	logic [25:0] k;
	logic [4:0]  op;
	int          n_errors = 0;
	int          n_tests = 0;
	int          seed = 81842;
	int          cyc = 0;
	// 125 MHz clock
	always #4 pclk = ~pclk;
	cibx_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	cibx_issue_model ISS (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ISS.xfer(1'b1, a, d, q, e);
	endtask : wr
	// Plain read with no command issued
	task automatic rd(input logic [7:0] a);
		ISS.xfer(1'b0, a, 32'h00000000, q, e);
	endtask : rd
	// Issue one command, then read one result register back
	task automatic run(input logic [4:0] o, input logic im, input logic [7:0] a);
		wr(CIBX_OFF_CMD, {k, im, o});
		ISS.xfer(1'b0, a, 32'h00000000, q, e);
	endtask : run
	function automatic logic [31:0] tgt(input logic [31:0] p, input logic [25:0] o);
		return p + 32'h00000004 + {{4{o[25]}}, o, 2'b00};
	endfunction : tgt
	// Overflow is carry out of bit 31 against carry out of bit 30
	function automatic logic [31:0] addfl(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] w;
		logic [31:0] l;
		w = {1'b0, a} + {1'b0, b};
		l = {1'b0, a[30:0]} + {1'b0, b[30:0]};
		return {30'h0, w[32] ^ l[31], $signed(b) < $signed(-a)};
	endfunction : addfl
	task automatic final_report;
		$display("Checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// Hang guard; the run needs only a few thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
	// Main sequence: corner values first, then random operands
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			s1 = (i == 0) ? 32'h80000000 : $random(seed);
			s2 = (i < 2) ? 32'h80000000 * i : $random(seed);
			k = 26'($random(seed));
			pc = $random(seed) & 32'hFFFFFFFC;
			wr(CIBX_OFF_SRC1, s1);
			wr(CIBX_OFF_SRC2, s2);
			run(5'h01, 1'b0, CIBX_OFF_RESULT);
			chk(q, s1 + s2);
			run(5'h01, 1'b0, CIBX_OFF_FLAGS);
			chk(q & 32'h00000003, addfl(s1, s2));
			op = 5'h02 + i[1:0];
			r = (op[0] ? {k[15:0], 16'h0000} : {16'h0000, k[15:0]});
			r = ((op > 5'h03) ? ~r : r) & s2;
			run(op, 1'b1, CIBX_OFF_RESULT);
			chk(q, r);
			run(op, 1'b1, CIBX_OFF_FLAGS);
			chk(q & 32'h00000001, {31'h0, r == 32'h0});
			c = i[2];
			op = 5'h06 + i[1:0];
			t = (op < 5'h08) ? c : !c;
			wr(CIBX_OFF_FLAGS, {31'h0, c});
			wr(CIBX_OFF_PC, pc);
			run(op, 1'b0, CIBX_OFF_NPC);
			chk(q, t ? tgt(pc, k) : pc + 32'h00000004);
			run(op, 1'b0, CIBX_OFF_SEQ);
			chk(q & 32'h00000007, op[0] ? (t ? 32'h3 : 32'h4) : {31'h0, t});
			run(5'h0D + i[0], 1'b0, CIBX_OFF_LINK);
			chk(q, pc + 32'h00000008);
			run(5'h0B, 1'b0, CIBX_OFF_NPC);
			chk(q, tgt(pc, k));
			wr(CIBX_OFF_MERGE, s2);
			run(5'h13, 1'b0, CIBX_OFF_RESULT);
			chk(q, s1 | s2);
			ISS.xfer(1'b0, CIBX_OFF_MERGE, 32'h0, q, e);
			chk(q, 32'h0);
			wr(CIBX_OFF_FREG, s1 ^ s2);
			run(5'h15, 1'b0, CIBX_OFF_RESULT);
			chk(q, s1 ^ s2);
			run(5'h16, 1'b0, CIBX_OFF_RESULT);
			chk(q, s1 ^ s2);
			run(5'h14, 1'b0, CIBX_OFF_RESULT);
			chk(q, (s2 <= s1) ? s2 : s1);
			// Compare branches; bit 3 forces equality, bit 1 picks the short immediate
			opnd = i[1] ? {27'h0, k[4:0]} : s1;
			cmpv = i[3] ? opnd : s2;
			wr(CIBX_OFF_SRC2, cmpv);
			run(5'h0F + i[0], i[1], CIBX_OFF_NPC);
			chk(q, ((opnd == cmpv) ^ i[0]) ? tgt(pc, {{10{k[15]}}, k[15:0]}) : pc + 32'h4);
			// Loop add: branch on the old loop flag, temp flag from the original src2
			wr(CIBX_OFF_SRC2, s2);
			wr(CIBX_OFF_FLAGS, {29'h0, c, 2'b00});
			run(5'h0A, 1'b0, CIBX_OFF_NPC);
			chk(q, c ? tgt(pc, {{10{k[15]}}, k[15:0]}) : pc + 32'h4);
			r = addfl(s1, s2);
			rd(CIBX_OFF_FLAGS);
			chk(q & 32'h4, {29'h0, !r[0], 2'b00});
			rd(CIBX_OFF_SEQ);
			chk(q, {30'h0, 1'b1, c});
			rd(CIBX_OFF_SRC2);
			chk(q, s1 + s2);
			// Autoincrement load or store
			wr(CIBX_OFF_SRC2, s2);
			run(5'h11 + i[0], 1'b0, CIBX_OFF_RESULT);
			chk(q, s1 + s2);
			rd(CIBX_OFF_SRC2);
			chk(q, s1 + s2);
			// Trap return: dual flag from bit 0, delayed switch from bit 1
			wr(CIBX_OFF_FLAGS, {26'h0, 1'b1, i[0], i[1], 3'b000});
			run(5'h0C, 1'b0, CIBX_OFF_FLAGS);
			chk(q & 32'h70, {25'h0, i[0], 1'b0, i[0], 4'h0});
			run(5'h00, 1'b0, CIBX_OFF_FLAGS);
			chk(q & 32'h40, {25'h0, i[1] ? !i[0] : i[0], 6'h0});
		end
		run(5'h17, 1'b0, CIBX_OFF_SEQ);
		chk(q, 32'h8);
		ISS.xfer(1'b0, 8'h2C, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		final_report();
	end
endmodule : cibx_core_tb
